// File: ptt_pkg.sv
// Operation
// - power-on clear runs at power-up while the disable input is low
// - master clear high resets the counter; low lets it count
// - any reset clears all counter stages together
// - two select inputs pick divide by 2^8, 2^10, 2^13 or 2^16
// - upper and lower select both high pick the 2^16 tap
// - upper select high with lower select low picks the 2^8 tap
// - tap 2^n is the true output of stage n
// - during reset_any the output equals the polarity input; nrst low drives it low
// - repeat mode passes the selected tap to the output continuously
// - one-shot: latch clears at reset, sets after 2^(n-1) counts
// - one-shot output freezes; master clear or mode change restarts
// - master clear pulse clears counter and latch, output goes to the polarity level
// - each master clear pulse restarts the interval from zero
package ptt_pkg;
    localparam int CNT_W = 16;
    localparam logic [3:0] TAP_IDX_16 = 4'hf;
    localparam logic [3:0] TAP_IDX_8 = 4'h7;
    localparam logic [3:0] TAP_IDX_10 = 4'h9;
    localparam logic [3:0] TAP_IDX_13 = 4'hc;
    localparam int OSC_RATE_KHZ = 1000;
    localparam int CLK_RATE_KHZ = 25000;
    localparam logic [7:0] OSC_HALF_CYC =
        8'((CLK_RATE_KHZ / OSC_RATE_KHZ) / 2);
    localparam logic [4:0] POR_CYC = 5'h10;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam int CTRL_SOFT_CLR = 0;
    localparam int CTRL_EXT_CLK = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int STAT_OUT = 0;
    localparam int STAT_LATCH = 1;
    localparam int STAT_RESET = 2;
    localparam int PIN_N = 7;
    localparam int PIN_MCLR = 0;
    localparam int PIN_SEL_UP = 1;
    localparam int PIN_SEL_LO = 2;
    localparam int PIN_POL = 3;
    localparam int PIN_REPEAT = 4;
    localparam int PIN_POR_DIS = 5;
    localparam int PIN_EXT_CLK = 6;
endpackage

`timescale 1ns/1ps
`default_nettype none
module ptt_sync
#(
    parameter int W = 1
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb
    begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule // ptt_sync
`default_nettype wire

// File: ptt_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ptt_timer
    import ptt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic master_clear,
    input wire logic tap_sel_upper,
    input wire logic tap_sel_lower,
    input wire logic out_polarity,
    input wire logic mode_repeat,
    input wire logic por_disable,
    input wire logic ext_clk,
    output logic timer_out,
    output logic osc_resistor_node,
    output logic osc_capacitor_node,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    function automatic logic [3:0] tap_index(input logic up,
                                             input logic lo);
        logic [3:0] idx;
        idx = TAP_IDX_13;
        if (up && lo)
            idx = TAP_IDX_16;
        else if (up)
            idx = TAP_IDX_8;
        else if (lo)
            idx = TAP_IDX_10;
        return idx;
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_COUNT);
    endfunction

    logic [PIN_N-1:0] pins_raw;
    logic [PIN_N-1:0] pins;

    assign pins_raw = {ext_clk, por_disable, mode_repeat, out_polarity,
                       tap_sel_lower, tap_sel_upper, master_clear};

    ptt_sync #(.W(PIN_N)) u_sync
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .d(pins_raw),
        .q(pins)
    );

    // control register and bus
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;
    logic [31:0] next_prdata;
    logic wr_en;
    logic setup;

    // power-on clear
    logic [4:0] por_cnt;
    logic [4:0] next_por_cnt;
    logic por_done;
    logic next_por_done;
    logic por_active;

    // oscillator and edge detect
    logic [7:0] osc_cnt;
    logic [7:0] next_osc_cnt;
    logic osc_phase;
    logic next_osc_phase;
    logic ext_prev;
    logic next_ext_prev;
    logic mode_prev;
    logic next_mode_prev;
    logic osc_tick;
    logic tick;

    // counter and output
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic latch;
    logic next_latch;
    logic out_q;
    logic next_out_q;
    logic reset_any;
    logic tap;
    logic count_en;
    logic [CNT_W-1:0] carry;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && reg_hit(paddr);
    assign pready = psel && penable;
    assign pslverr = psel && penable && !reg_hit(paddr);

    assign por_active = !por_done && !pins[PIN_POR_DIS];
    assign reset_any = por_active || pins[PIN_MCLR]
                    || ctrl[CTRL_SOFT_CLR]
                    || (pins[PIN_REPEAT] != mode_prev);
    assign tap = count[tap_index(pins[PIN_SEL_UP],
                                 pins[PIN_SEL_LO])];
    assign osc_tick = (osc_cnt == OSC_HALF_CYC - 8'h01) && !osc_phase;
    assign tick = ctrl[CTRL_EXT_CLK] ? (pins[PIN_EXT_CLK] && !ext_prev)
                                     : osc_tick;
    assign count_en = tick && !(!pins[PIN_REPEAT] && latch);
    assign carry[0] = count_en;

    // each stage toggles once every lower stage is high
    generate
        for (genvar g = 1; g < CNT_W; g++)
        begin : g_stage
            assign carry[g] = carry[g-1] && count[g-1];
        end
    endgenerate

    always_comb
    begin
        next_ctrl = ctrl;
        if (wr_en && paddr == REG_CTRL)
            next_ctrl = pwdata[1:0];
        next_prdata = prdata;
        if (setup)
        begin
            next_prdata = 32'h0;
            unique case (paddr)
                REG_CTRL: next_prdata[1:0] = ctrl;
                REG_STATUS:
                begin
                    next_prdata[STAT_OUT] = out_q;
                    next_prdata[STAT_LATCH] = latch;
                    next_prdata[STAT_RESET] = reset_any;
                end
                REG_COUNT: next_prdata[CNT_W-1:0] = count;
                default: next_prdata = 32'h0;
            endcase
        end
    end

    always_comb
    begin
        next_por_cnt = por_cnt;
        next_por_done = por_done;
        if (!por_done)
        begin
            next_por_cnt = por_cnt + 5'h01;
            if (pins[PIN_POR_DIS] || por_cnt == POR_CYC - 5'h01)
                next_por_done = 1'b1;
        end
    end

    always_comb
    begin
        next_ext_prev = pins[PIN_EXT_CLK];
        next_mode_prev = pins[PIN_REPEAT];
        next_osc_cnt = osc_cnt;
        next_osc_phase = osc_phase;
        if (reset_any || ctrl[CTRL_EXT_CLK])
        begin
            next_osc_cnt = 8'h00;
            next_osc_phase = 1'b0;
        end
        else if (osc_cnt == OSC_HALF_CYC - 8'h01)
        begin
            next_osc_cnt = 8'h00;
            next_osc_phase = !osc_phase;
        end
        else
            next_osc_cnt = osc_cnt + 8'h01;
    end

    always_comb
    begin
        next_count = count;
        next_latch = latch;
        next_out_q = out_q;
        if (reset_any)
        begin
            next_count = '0;
            next_latch = 1'b0;
            next_out_q = pins[PIN_POL];
        end
        else
        begin
            next_count = count ^ carry;
            if (!pins[PIN_REPEAT] && tap)
                next_latch = 1'b1;
            if (pins[PIN_REPEAT])
                next_out_q = tap ^ pins[PIN_POL];
            else
                next_out_q = (latch || tap) ^ pins[PIN_POL];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            ctrl <= CTRL_RESET;
            prdata <= 32'h0;
        end
        else
        begin
            ctrl <= next_ctrl;
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            por_cnt <= 5'h00;
            por_done <= 1'b0;
        end
        else
        begin
            por_cnt <= next_por_cnt;
            por_done <= next_por_done;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            osc_cnt <= 8'h00;
            osc_phase <= 1'b0;
            ext_prev <= 1'b0;
            mode_prev <= 1'b0;
        end
        else
        begin
            osc_cnt <= next_osc_cnt;
            osc_phase <= next_osc_phase;
            ext_prev <= next_ext_prev;
            mode_prev <= next_mode_prev;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            count <= '0;
            latch <= 1'b0;
            out_q <= 1'b0;
        end
        else
        begin
            count <= next_count;
            latch <= next_latch;
            out_q <= next_out_q;
        end
    end

    assign timer_out = out_q;
    assign osc_resistor_node = osc_phase;
    assign osc_capacitor_node = !osc_phase;
endmodule // ptt_timer
`default_nettype wire

// File: ptt_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ptt_timer_chk
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic master_clear,
    input wire logic out_polarity,
    input wire logic por_disable,
    input wire logic timer_out,
    input wire logic osc_resistor_node,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    a_clear_level: assert property ($rose(master_clear) ##0
        (master_clear && $stable(out_polarity))[*6]
        |-> timer_out == out_polarity) else $error("clear level");
    a_clear_osc: assert property (master_clear[*6]
        |-> $stable(osc_resistor_node)) else $error("osc runs");
    a_por_level: assert property ($rose(nrst) ##0
        (!por_disable && !master_clear && $stable(out_polarity))[*5]
        |-> timer_out == out_polarity) else $error("por level");
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("no ready");
    a_ready_idle: assert property (!(psel && penable) |-> !pready)
        else $error("stray ready");
    a_err_unmapped: assert property (psel && penable
        && !(paddr inside {8'h00, 8'h04, 8'h08})
        |-> pslverr && prdata == 32'h0) else $error("no error");
    a_err_mapped: assert property (psel && penable && paddr == 8'h08
        |-> !pslverr) else $error("false error");
    a_rdata_hold: assert property (!(psel && !penable)
        |=> $stable(prdata)) else $error("read data moved");
    c_clear: cover property ($rose(master_clear));
    c_err: cover property (pslverr);
    c_out: cover property ($rose(timer_out));
endmodule // ptt_timer_chk
bind ptt_timer ptt_timer_chk i_chk
(
    .clk_sys(clk_sys),
    .nrst(nrst),
    .master_clear(master_clear),
    .out_polarity(out_polarity),
    .por_disable(por_disable),
    .timer_out(timer_out),
    .osc_resistor_node(osc_resistor_node),
    .psel(psel),
    .penable(penable),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
);
`default_nettype wire

// File: ptt_board.sv
`timescale 1ns/1ps
`default_nettype none
module ptt_board
(
    input wire logic clk_sys,
    output var logic ext_clk
);
    initial ext_clk = 1'b0;
    // count clock, still between bursts, each level w >= 2 cycles
    task automatic burst(input int n, input int w);
        repeat (n)
        begin
            ext_clk <= 1'b1;
            repeat (w) @(posedge clk_sys);
            ext_clk <= 1'b0;
            repeat (w) @(posedge clk_sys);
        end
    endtask
endmodule // ptt_board
`default_nettype wire

// File: ptt_testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ptt_pkg::*;
    logic clk_sys = 1'b0, nrst = 1'b0, master_clear = 1'b0;
    logic tap_sel_upper = 1'b0, tap_sel_lower = 1'b0, out_polarity = 1'b1;
    logic mode_repeat = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic por_disable = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hbd99;
    logic ext_clk, timer_out, pready, pslverr, err;
    int n_fail = 0, samples_checked = 0;
    always #20 clk_sys = ~clk_sys;
    ptt_board i_board (.clk_sys(clk_sys), .ext_clk(ext_clk));
    ptt_timer i_dut (.clk_sys(clk_sys), .nrst(nrst),
        .master_clear(master_clear), .tap_sel_upper(tap_sel_upper),
        .tap_sel_lower(tap_sel_lower), .out_polarity(out_polarity),
        .mode_repeat(mode_repeat), .por_disable(por_disable),
        .ext_clk(ext_clk),
        .timer_out(timer_out), .osc_resistor_node(),
        .osc_capacitor_node(), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic int tap_n(input logic up, input logic lo);
        return up ? (lo ? 16 : 8) : (lo ? 10 : 13);
    endfunction
    function automatic logic exp_out(int n, logic rep, logic pol, int t);
        if (rep)
            return pol ^ t[n-1];
        return pol ^ (t >= (1 << (n - 1)));
    endfunction
    function automatic logic [31:0] exp_cnt(int n, logic rep, int t);
        return (rep || t < (1 << (n - 1))) ? t : (1 << (n - 1));
    endfunction
    task automatic report_and_stop;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic exp);
        @(negedge clk_sys);
        chk_word({31'h0, timer_out}, {31'h0, exp});
        @(posedge clk_sys);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    initial
    begin
        repeat (95000) @(posedge clk_sys);
        n_fail++;
        report_and_stop;
    end
    initial
    begin
        int n, t;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, REG_STATUS, 32'h0);
        chk_word(rd & 32'h4, 32'h4);
        chk_pin(1'b1);
        repeat (30) @(posedge clk_sys);
        apb(1'b0, REG_STATUS, 32'h0);
        chk_word(rd & 32'h4, 32'h0);
        master_clear <= 1'b1;
        repeat (8) @(posedge clk_sys);
        apb(1'b0, REG_COUNT, 32'h0);
        chk_word(rd, 32'h0);
        master_clear <= 1'b0;
        apb(1'b1, REG_CTRL, 32'h2);
        apb(1'b0, REG_CTRL, 32'h0);
        chk_word(rd, 32'h2);
        apb(1'b0, 8'h0c, 32'h0);
        chk_word({rd[30:0], err}, 32'h1);
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            n = tap_n(i[0], i[1]);
            t = (n == 16) ? seed % 700 : (1 << (n - 1)) + seed % 300;
            tap_sel_upper <= i[0];
            tap_sel_lower <= i[1];
            mode_repeat <= i[2];
            out_polarity <= seed[20];
            @(posedge clk_sys);
            master_clear <= 1'b1;
            repeat (8) @(posedge clk_sys);
            apb(1'b0, REG_COUNT, 32'h0);
            chk_word(rd, 32'h0);
            chk_pin(out_polarity);
            master_clear <= 1'b0;
            repeat (4) @(posedge clk_sys);
            i_board.burst(t, 2 + seed[3]);
            repeat (6) @(posedge clk_sys);
            apb(1'b0, REG_COUNT, 32'h0);
            chk_word(rd, exp_cnt(n, i[2], t));
            chk_pin(exp_out(n, i[2], out_polarity, t));
        end
        por_disable <= 1'b1;
        nrst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        apb(1'b0, REG_STATUS, 32'h0);
        chk_word(rd & 32'h4, 32'h0);
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
